// *** hdl/ulc_line_ctrl.sv ***
`timescale 1ns/100ps
`include "ulc_params.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module ulc_line_ctrl #(
    parameter int BAUD_DIV = `ULC_BAUD_DIV, // ref_clk cycles per 16x sample tick
    parameter int DEPTH = 16 // receive and transmit fifo depth, power of two
) (
    input wire logic ref_clk, // 125 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic [2:0] regAddr, // register offset
    input wire logic regWrEn, // write strobe
    input wire logic regRdEn, // read strobe
    input wire logic [7:0] regWrData, // write data
    output logic [7:0] regRdData, // read data, one cycle after strobe
    input wire logic fifoEnable, // fifo operation when high
    input wire logic serialInPin, // serial input
    output logic serialOutPin, // serial output
    output logic rxLineIrq, // receiver line status interrupt
    output logic txEmptyIrq // holding empty interrupt
);
    typedef struct packed {
        logic [15:0] divCnt;
        logic tick;
        logic [2:0] inSync;
        logic rxLine;
        logic [7:0] line_format_control;
        logic [7:0] peripheral_link_control;
        logic [7:0] interrupt_enable_reg;
        ulc_pkg::ulc_rx_t rxSt;
        logic [5:0] rxCnt;
        logic [2:0] rxBit;
        logic [7:0] rxShift;
        logic rxPar;
        logic rxAllZero;
        logic [1:0] rxHigh;
        ulc_pkg::ulc_tx_t txSt;
        logic [5:0] txCnt;
        logic [2:0] txBit;
        logic [7:0] txShift;
        logic txOut;
        logic txParBit;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic fifoErr;
        logic headSeen;
        logic [4:0] errCount;
        logic [7:0] rdData;
        logic serialOut;
        logic rxIrq;
        logic txIrq;
    } ulc_state_t;

    ulc_state_t s_r;
    ulc_state_t s_nxt;

    logic rxPush, rxPushAcc, rxPop, rxPopAct, rxEmpty, rxFull, rxIn, overwrite;
    logic txPush, txLoad, txEmpty, txFull, lsrRead, dataWr, tx_all_empty_flag;
    logic [7:0] txHead, lsrVal;
    logic [2:0] lastBit;
    logic [5:0] stopEnd;
    ulc_pkg::ulc_rxent_t rxEnt, rxHead;

    function automatic logic [7:0] lenMask(input logic [1:0] wl);
        return 8'hFF >> (2'h3 - wl);
    endfunction

    function automatic logic parityOf(input logic [7:0] d, input logic [7:0] line_format_control);
        if (line_format_control[`ULC_LCR_STICK]) begin
            return !line_format_control[`ULC_LCR_EVEN];
        end
        return line_format_control[`ULC_LCR_EVEN] ? ^d : !(^d);
    endfunction

    ulc_fifo #(.WIDTH(11), .DEPTH(DEPTH)) rxFifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .capOne(!fifoEnable),
        .push(rxPushAcc),
        .pushData(rxEnt),
        .pop(rxPopAct),
        .headData(rxHead),
        .empty(rxEmpty),
        .full(rxFull)
    );

    ulc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .capOne(!fifoEnable),
        .push(txPush),
        .pushData(regWrData),
        .pop(txLoad),
        .headData(txHead),
        .empty(txEmpty),
        .full(txFull)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        rxPush = 1'b0;
        rxEnt = '0;
        txLoad = 1'b0;
        lastBit = 3'h4 + 3'(s_r.line_format_control[1:0]);
        // one stop unless the stop bit is set; then 1.5 stops with five bits, two otherwise
        stopEnd = !s_r.line_format_control[`ULC_LCR_STOP] ? `ULC_STOP_ONE :
            (s_r.line_format_control[1:0] == 2'h0) ? `ULC_STOP_HALF : `ULC_STOP_TWO;
        rxIn = s_r.peripheral_link_control[`ULC_MCR_LOOP] ? s_r.txOut : s_r.rxLine;
        dataWr = regWrEn && !s_r.line_format_control[`ULC_LCR_DLS];
        txPush = dataWr && (regAddr == `ULC_OFS_DATA);
        rxPop = regRdEn && !s_r.line_format_control[`ULC_LCR_DLS] && (regAddr == `ULC_OFS_DATA);
        lsrRead = regRdEn && (regAddr == `ULC_OFS_LSR);
        tx_all_empty_flag = txEmpty && (s_r.txSt == ulc_pkg::TX_IDLE);
        lsrVal = {s_r.fifoErr, tx_all_empty_flag, txEmpty, s_r.bi, s_r.fe, s_r.pe, s_r.oe, !rxEmpty};

        // 16x sample tick
        s_nxt.tick = 1'b0;
        if (s_r.divCnt == 16'(BAUD_DIV - 1)) begin
            s_nxt.divCnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.divCnt = s_r.divCnt + 16'h0001;
        end
        s_nxt.inSync = {s_r.inSync[1:0], serialInPin};
        if (s_r.inSync[1] == s_r.inSync[2]) begin
            s_nxt.rxLine = s_r.inSync[1];
        end

        // register writes; mcr bits other than loop only store
        if (regWrEn && regAddr == `ULC_OFS_LCR) begin
            s_nxt.line_format_control = regWrData;
        end
        if (regWrEn && regAddr == `ULC_OFS_MCR) begin
            s_nxt.peripheral_link_control = regWrData;
        end
        if (dataWr && regAddr == `ULC_OFS_IER) begin
            s_nxt.interrupt_enable_reg = regWrData;
        end

        ////////////////////////////////////////////////////////////////////////
        // receiver
        if (s_r.tick) begin
            case (s_r.rxSt)
                ulc_pkg::RX_IDLE: begin
                    s_nxt.rxCnt = '0;
                    if (!rxIn) begin
                        s_nxt.rxSt = ulc_pkg::RX_START;
                    end
                end
                ulc_pkg::RX_START: begin
                    s_nxt.rxCnt = s_r.rxCnt + 6'h01;
                    if (rxIn) begin
                        s_nxt.rxSt = ulc_pkg::RX_IDLE;
                    end else if (s_r.rxCnt == `ULC_SMP_MID) begin
                        s_nxt.rxSt = ulc_pkg::RX_DATA;
                        s_nxt.rxCnt = '0;
                        s_nxt.rxBit = '0;
                        s_nxt.rxShift = '0;
                        s_nxt.rxAllZero = 1'b1;
                    end
                end
                ulc_pkg::RX_DATA: begin
                    s_nxt.rxCnt = s_r.rxCnt + 6'h01;
                    if (s_r.rxCnt == `ULC_SMP_LAST) begin
                        s_nxt.rxCnt = '0;
                        s_nxt.rxShift[s_r.rxBit] = rxIn;
                        s_nxt.rxAllZero = s_r.rxAllZero && !rxIn;
                        s_nxt.rxBit = s_r.rxBit + 3'h1;
                        if (s_r.rxBit == lastBit) begin
                            s_nxt.rxSt = s_r.line_format_control[`ULC_LCR_PEN] ? ulc_pkg::RX_PAR : ulc_pkg::RX_STOP;
                        end
                    end
                end
                ulc_pkg::RX_PAR: begin
                    s_nxt.rxCnt = s_r.rxCnt + 6'h01;
                    if (s_r.rxCnt == `ULC_SMP_LAST) begin
                        s_nxt.rxCnt = '0;
                        s_nxt.rxPar = rxIn;
                        s_nxt.rxAllZero = s_r.rxAllZero && !rxIn;
                        s_nxt.rxSt = ulc_pkg::RX_STOP;
                    end
                end
                ulc_pkg::RX_STOP: begin
                    s_nxt.rxCnt = s_r.rxCnt + 6'h01;
                    if (s_r.rxCnt == `ULC_SMP_LAST) begin
                        rxPush = 1'b1;
                        rxEnt.data = s_r.rxShift;
                        rxEnt.par = s_r.line_format_control[`ULC_LCR_PEN] &&
                            (s_r.rxPar != parityOf(s_r.rxShift, s_r.line_format_control));
                        s_nxt.rxCnt = '0;
                        s_nxt.rxSt = ulc_pkg::RX_IDLE;
                        if (!rxIn && s_r.rxAllZero) begin
                            // low through the whole frame: one zero character only
                            rxEnt = '0;
                            rxEnt.brk = 1'b1;
                            s_nxt.rxHigh = '0;
                            s_nxt.rxSt = ulc_pkg::RX_BRKW;
                        end else if (!rxIn) begin
                            rxEnt.frm = 1'b1;
                            // the low stop is taken as the next start, checked once more
                            s_nxt.rxCnt = `ULC_RESYNC_CNT;
                            s_nxt.rxSt = ulc_pkg::RX_START;
                        end
                    end
                end
                ulc_pkg::RX_BRKW: begin
                    s_nxt.rxHigh = rxIn ? s_r.rxHigh + 2'h1 : 2'h0;
                    if (rxIn && (s_r.rxHigh + 2'h1 == `ULC_BRK_HIGH)) begin
                        s_nxt.rxSt = ulc_pkg::RX_IDLE;
                    end
                end
                default: begin
                    s_nxt.rxSt = ulc_pkg::RX_IDLE;
                end
            endcase
        end

        // receive buffer: fifo drops the new character, single buffer overwrites
        overwrite = rxPush && rxFull && !fifoEnable;
        rxPushAcc = rxPush && (!rxFull || !fifoEnable);
        rxPopAct = (rxPop && !rxEmpty) || overwrite;

        // parity, framing and break errors travel with their character and show at the head
        if (lsrRead) begin
            s_nxt.oe = 1'b0;
            s_nxt.pe = 1'b0;
            s_nxt.fe = 1'b0;
            s_nxt.bi = 1'b0;
        end
        if (rxPush && rxFull) begin
            s_nxt.oe = 1'b1;
        end
        if (!rxEmpty && !s_r.headSeen) begin
            s_nxt.pe = s_nxt.pe || rxHead.par;
            s_nxt.fe = s_nxt.fe || rxHead.frm;
            s_nxt.bi = s_nxt.bi || rxHead.brk;
            s_nxt.headSeen = 1'b1;
        end
        if (rxPopAct) begin
            s_nxt.headSeen = 1'b0;
        end
        s_nxt.errCount = s_r.errCount + 5'(rxPushAcc && (rxEnt.par || rxEnt.frm || rxEnt.brk))
            - 5'(rxPopAct && (rxHead.par || rxHead.frm || rxHead.brk));
        s_nxt.fifoErr = fifoEnable && ((s_r.errCount != '0) || (s_r.fifoErr && !lsrRead));

        ////////////////////////////////////////////////////////////////////////
        // transmitter; shifter runs freely, break only touches the pin
        case (s_r.txSt)
            ulc_pkg::TX_IDLE: begin
                s_nxt.txOut = 1'b1;
                if (!txEmpty) begin
                    txLoad = 1'b1;
                    s_nxt.txShift = txHead & lenMask(s_r.line_format_control[1:0]);
                    s_nxt.txParBit = parityOf(txHead & lenMask(s_r.line_format_control[1:0]), s_r.line_format_control);
                    s_nxt.txCnt = '0;
                    s_nxt.txOut = 1'b0;
                    s_nxt.txSt = ulc_pkg::TX_START;
                end
            end
            ulc_pkg::TX_START: begin
                if (s_r.tick) begin
                    s_nxt.txCnt = s_r.txCnt + 6'h01;
                    if (s_r.txCnt == `ULC_SMP_LAST) begin
                        s_nxt.txCnt = '0;
                        s_nxt.txBit = '0;
                        s_nxt.txOut = s_r.txShift[0];
                        s_nxt.txSt = ulc_pkg::TX_DATA;
                    end
                end
            end
            ulc_pkg::TX_DATA: begin
                if (s_r.tick) begin
                    s_nxt.txCnt = s_r.txCnt + 6'h01;
                    if (s_r.txCnt == `ULC_SMP_LAST) begin
                        s_nxt.txCnt = '0;
                        s_nxt.txBit = s_r.txBit + 3'h1;
                        s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
                        s_nxt.txOut = s_r.txShift[1];
                        if (s_r.txBit == lastBit) begin
                            s_nxt.txOut = s_r.line_format_control[`ULC_LCR_PEN] ? s_r.txParBit : 1'b1;
                            s_nxt.txSt = s_r.line_format_control[`ULC_LCR_PEN] ? ulc_pkg::TX_PAR : ulc_pkg::TX_STOP;
                        end
                    end
                end
            end
            ulc_pkg::TX_PAR: begin
                if (s_r.tick) begin
                    s_nxt.txCnt = s_r.txCnt + 6'h01;
                    if (s_r.txCnt == `ULC_SMP_LAST) begin
                        s_nxt.txCnt = '0;
                        s_nxt.txOut = 1'b1;
                        s_nxt.txSt = ulc_pkg::TX_STOP;
                    end
                end
            end
            ulc_pkg::TX_STOP: begin
                if (s_r.tick) begin
                    s_nxt.txCnt = s_r.txCnt + 6'h01;
                    if (s_r.txCnt >= stopEnd) begin
                        s_nxt.txCnt = '0;
                        s_nxt.txSt = ulc_pkg::TX_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.txSt = ulc_pkg::TX_IDLE;
            end
        endcase

        s_nxt.serialOut = s_r.peripheral_link_control[`ULC_MCR_LOOP] ? 1'b1 :
            s_r.line_format_control[`ULC_LCR_BRK] ? 1'b0 : s_nxt.txOut;
        s_nxt.rxIrq = s_r.interrupt_enable_reg[`ULC_IER_RLS] && (s_nxt.oe || s_nxt.pe || s_nxt.fe || s_nxt.bi);
        s_nxt.txIrq = s_r.interrupt_enable_reg[`ULC_IER_TX_HOLDING_EMPTY_FLAG] && txEmpty;

        // read data; divisor latches are outside this block and read zero
        s_nxt.rdData = s_r.rdData;
        if (regRdEn) begin
            case (regAddr)
                `ULC_OFS_DATA: s_nxt.rdData = s_r.line_format_control[`ULC_LCR_DLS] ? 8'h00 : rxHead.data;
                `ULC_OFS_IER: s_nxt.rdData = s_r.line_format_control[`ULC_LCR_DLS] ? 8'h00 : s_r.interrupt_enable_reg;
                `ULC_OFS_LCR: s_nxt.rdData = s_r.line_format_control;
                `ULC_OFS_MCR: s_nxt.rdData = s_r.peripheral_link_control;
                `ULC_OFS_LSR: s_nxt.rdData = lsrVal;
                default: s_nxt.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.inSync <= 3'h7;
            s_r.rxLine <= 1'b1;
            s_r.line_format_control <= `ULC_LCR_RST;
            s_r.peripheral_link_control <= `ULC_MCR_RST;
            s_r.interrupt_enable_reg <= `ULC_IER_RST;
            s_r.rxSt <= ulc_pkg::RX_IDLE;
            s_r.txSt <= ulc_pkg::TX_IDLE;
            s_r.txOut <= 1'b1;
            s_r.serialOut <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign regRdData = s_r.rdData;
    assign serialOutPin = s_r.serialOut;
    assign rxLineIrq = s_r.rxIrq;
    assign txEmptyIrq = s_r.txIrq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_loop_out_high: assert property (s_r.peripheral_link_control[`ULC_MCR_LOOP] |=> serialOutPin)
        else $error("loopback did not hold output high");
    chk_break_out_low: assert property (s_r.line_format_control[`ULC_LCR_BRK] && !s_r.peripheral_link_control[`ULC_MCR_LOOP] |=> !serialOutPin)
        else $error("break did not force output low");
    chk_lsr_read_clear: assert property (lsrRead && !rxPush && (rxEmpty || s_r.headSeen) |=>
        !(s_r.oe || s_r.pe || s_r.fe || s_r.bi)) else $error("status read left error set");
    chk_overrun_fifo: assert property (rxPush && rxFull && fifoEnable |=> s_r.oe && $stable(rxEmpty))
        else $error("fifo overrun not flagged");
    chk_data_ready: assert property (rxPush && !(rxFull && fifoEnable) |=> !rxEmpty)
        else $error("received character not ready");
    chk_tx_holding_empty_flag_load: assert property (txPush && !txFull |=> !txEmpty ##1 1'b1)
        else $error("holding empty not cleared by write");
    chk_tx_all_empty_flag_busy: assert property (lsrRead && s_r.txSt != ulc_pkg::TX_IDLE |=> !regRdData[6])
        else $error("all-empty read while shifting");
    chk_two_stops: assert property (s_r.txSt == ulc_pkg::TX_STOP && s_r.tick && s_r.line_format_control[`ULC_LCR_STOP] &&
        s_r.line_format_control[1:0] != 2'h0 && s_r.txCnt < 6'h1F |=> s_r.txSt == ulc_pkg::TX_STOP)
        else $error("stop time shorter than two bits");
    chk_fifo_error_summary_zero: assert property (!fifoEnable |=> !s_r.fifoErr)
        else $error("fifo error summary set outside fifo operation");
    chk_rls_irq: assert property (s_r.interrupt_enable_reg[`ULC_IER_RLS] && s_r.oe && !lsrRead |=> rxLineIrq)
        else $error("line status interrupt missing");
    chk_stick_par: assert property (txLoad && s_r.line_format_control[`ULC_LCR_PEN] && s_r.line_format_control[`ULC_LCR_STICK] |=>
        s_r.txParBit == !$past(s_r.line_format_control[`ULC_LCR_EVEN])) else $error("stick parity wrong");
    chk_break_wait: assert property (s_r.rxSt == ulc_pkg::RX_BRKW && !rxIn |=> s_r.rxSt == ulc_pkg::RX_BRKW)
        else $error("break left without high samples");

    cov_break_rx: cover property (rxPush && rxEnt.brk);
    cov_fifo_overrun: cover property (rxPush && rxFull && fifoEnable);
    cov_parity_tx: cover property (s_r.txSt == ulc_pkg::TX_PAR);
    cov_loop_rx: cover property (s_r.peripheral_link_control[`ULC_MCR_LOOP] && rxPush && !rxEnt.frm);
endmodule

// *** hdl/ulc_params.svh ***
`ifndef ULC_PARAMS_SVH
`define ULC_PARAMS_SVH
`define ULC_OFS_DATA 3'h0
`define ULC_OFS_IER 3'h1
`define ULC_OFS_LCR 3'h3
`define ULC_OFS_MCR 3'h4
`define ULC_OFS_LSR 3'h5
`define ULC_LCR_RST 8'h00
`define ULC_MCR_RST 8'h00
`define ULC_IER_RST 8'h00
`define ULC_LCR_STOP 2
`define ULC_LCR_PEN 3
`define ULC_LCR_EVEN 4
`define ULC_LCR_STICK 5
`define ULC_LCR_BRK 6
`define ULC_LCR_DLS 7
`define ULC_MCR_LOOP 4
`define ULC_IER_TX_HOLDING_EMPTY_FLAG 1
`define ULC_IER_RLS 2
`define ULC_SMP_MID 6'h07
`define ULC_SMP_LAST 6'h0F
`define ULC_STOP_ONE 6'h0F
`define ULC_STOP_HALF 6'h17
`define ULC_STOP_TWO 6'h1F
`define ULC_RESYNC_CNT 6'h06
`define ULC_BRK_HIGH 2'h2
`define ULC_BAUD_DIV 68
`endif

// *** hdl/ulc_pkg.sv ***
package ulc_pkg;
    typedef enum logic [5:0] {
        RX_IDLE = 6'h01,
        RX_START = 6'h02,
        RX_DATA = 6'h04,
        RX_PAR = 6'h08,
        RX_STOP = 6'h10,
        RX_BRKW = 6'h20
    } ulc_rx_t;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_PAR = 5'h08,
        TX_STOP = 5'h10
    } ulc_tx_t;
    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } ulc_rxent_t;
endpackage

// *** hdl/ulc_fifo.sv ***
`timescale 1ns/100ps
module ulc_fifo #(
    parameter int WIDTH = 8, // entry width
    parameter int DEPTH = 16, // entries, power of two
    parameter int AW = $clog2(DEPTH) // pointer width
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // async reset
    input wire logic capOne, // hold a single entry only
    input wire logic push, // write pushData
    input wire logic [WIDTH-1:0] pushData, // entry in
    input wire logic pop, // drop head entry
    output logic [WIDTH-1:0] headData, // oldest entry
    output logic empty, // no entry held
    output logic full // no room left
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
    } ulc_fifo_state_t;

    ulc_fifo_state_t s_r;
    ulc_fifo_state_t s_nxt;

    assign headData = s_r.mem[s_r.rdPtr];
    assign empty = (s_r.count == '0);
    // push while full is accepted only together with a pop
    assign full = capOne ? !empty : (s_r.count == (AW+1)'(DEPTH));

    always_comb begin
        s_nxt = s_r;
        if (pop && !empty) begin
            s_nxt.rdPtr = s_r.rdPtr + 1'b1;
            s_nxt.count = s_nxt.count - 1'b1;
        end
        if (push && (!full || pop)) begin
            s_nxt.mem[s_r.wrPtr] = pushData;
            s_nxt.wrPtr = s_r.wrPtr + 1'b1;
            s_nxt.count = s_nxt.count + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    chk_fifo_count_bound: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.count <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

// *** sim/ulc_serial_peer.sv ***
`timescale 1ns/100ps
module ulc_serial_peer #(
    parameter int BAUD_DIV = 2 // ref_clk cycles per 16x tick
) (
    input wire logic ref_clk, // system clock
    input wire logic lineIn, // from block serial output
    output logic lineOut // to block serial input, idle high
);
    localparam int BT = 16 * BAUD_DIV;
    initial lineOut = 1'b1;
    // caller supplies start, data, parity and stop bits, lsb first
    task automatic send(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            lineOut <= bits[i];
            repeat (BT) @(posedge ref_clk);
        end
        lineOut <= 1'b1;
        @(posedge ref_clk);
    endtask
    // sampled on the falling edge so the registered output has settled
    task automatic recv(input int n, output logic [15:0] bits, output logic ok);
        int w;
        bits = 16'h0000;
        w = 0;
        while (lineIn !== 1'b0 && w < 40 * BT) begin
            @(negedge ref_clk);
            w++;
        end
        ok = (lineIn === 1'b0);
        repeat (BT / 2) @(negedge ref_clk);
        for (int i = 0; i < n; i++) begin
            bits[i] = lineIn;
            repeat (BT) @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask
endmodule

// *** sim/uart_line_control_status_test.sv ***
`timescale 1ns/100ps
module uart_line_control_status_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic fifoEnable = 1'b0;
    logic serialInPin;
    logic serialOutPin;
    logic [7:0] regRdData;
    logic rxLineIrq;
    logic txEmptyIrq;
    logic [7:0] v;
    logic [15:0] f;
    logic ok;
    int miscompares = 0;
    int num_checks = 0;
    ulc_line_ctrl #(.BAUD_DIV(2), .DEPTH(16)) i_ulc_line_ctrl (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .fifoEnable(fifoEnable), .serialInPin(serialInPin), .serialOutPin(serialOutPin),
        .rxLineIrq(rxLineIrq), .txEmptyIrq(txEmptyIrq));
    ulc_serial_peer #(.BAUD_DIV(2)) i_ulc_serial_peer (.ref_clk(ref_clk), .lineIn(serialOutPin),
        .lineOut(serialInPin));
    initial forever #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
        @(posedge ref_clk);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
        rd(a, v);
        chk(what, {8'h00, v}, {8'h00, exp});
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_misc();
        int lows;
        lows = 0;
        wr(3'h1, 8'h02);
        #1 chk("tx irq", {15'h0, txEmptyIrq}, 16'h0001);
        wr(3'h1, 8'h00);
        // with divisor access set the enable register write must be ignored
        wr(3'h3, 8'h80);
        wr(3'h1, 8'h02);
        wr(3'h3, 8'h03);
        rdc(3'h1, 8'h00, "ier under divisor access");
        wr(3'h3, 8'h43);
        #1 chk("break out", {15'h0, serialOutPin}, 16'h0000);
        wr(3'h3, 8'h03);
        #1 chk("break off", {15'h0, serialOutPin}, 16'h0001);
        wr(3'h4, 8'h1F);
        // peer holds its line low the whole time; loopback must ignore it
        fork
            i_ulc_serial_peer.send(16'h0000, 14);
            begin
                wr(3'h0, 8'h5A);
                repeat (400) begin
                    @(posedge ref_clk);
                    lows += (serialOutPin !== 1'b1);
                end
            end
        join
        chk("loop out high", lows[15:0], 16'h0000);
        rdc(3'h0, 8'h5A, "loop data");
        wr(3'h4, 8'h00);
        $display("t_misc done");
    endtask
    task automatic t_tx(input logic [7:0] line_format_control, input logic [7:0] d, input int n, input logic [15:0] exp);
        wr(3'h3, line_format_control);
        fork
            begin
                wr(3'h0, d);
                rdc(3'h5, 8'h20, "lsr loaded");
            end
            i_ulc_serial_peer.recv(n, f, ok);
        join
        chk("tx start", {15'h0, ok}, 16'h0001);
        chk("tx frame", f, exp);
        rdc(3'h5, 8'h60, "lsr done");
        $display("t_tx %h done", line_format_control);
    endtask
    task automatic t_rx_par();
        fifoEnable <= 1'b0;
        wr(3'h3, 8'h0B);
        wr(3'h1, 8'h04);
        i_ulc_serial_peer.send(16'h0478, 11);
        #1 chk("line irq", {15'h0, rxLineIrq}, 16'h0001);
        rdc(3'h5, 8'h65, "lsr parity");
        rdc(3'h5, 8'h61, "lsr cleared");
        rdc(3'h0, 8'h3C, "rx data");
        rdc(3'h5, 8'h60, "lsr empty");
        #1 chk("line irq off", {15'h0, rxLineIrq}, 16'h0000);
        wr(3'h1, 8'h00);
        $display("t_rx_par done");
    endtask
    task automatic t_ovr();
        int i;
        wr(3'h3, 8'h03);
        i_ulc_serial_peer.send(16'h0222, 10);
        i_ulc_serial_peer.send(16'h0244, 10);
        rdc(3'h5, 8'h63, "lsr overrun");
        rdc(3'h0, 8'h22, "rx newest");
        fifoEnable <= 1'b1;
        for (i = 0; i < 17; i++) begin
            i_ulc_serial_peer.send({7'h01, i[7:0], 1'b0}, 10);
        end
        rdc(3'h5, 8'h63, "lsr fifo overrun");
        for (i = 0; i < 16; i++) begin
            rdc(3'h0, i[7:0], "rx fifo");
        end
        rdc(3'h5, 8'h60, "lsr drained");
        $display("t_ovr done");
    endtask
    task automatic t_brk();
        i_ulc_serial_peer.send(16'h0222, 10);
        i_ulc_serial_peer.send(16'h0000, 12);
        repeat (8) @(posedge ref_clk);
        rdc(3'h5, 8'hE1, "lsr good head");
        rdc(3'h0, 8'h11, "rx before break");
        rdc(3'h5, 8'hF1, "lsr break");
        rdc(3'h0, 8'h00, "break char");
        rd(3'h5, v);
        chk("lsr one break", {9'h000, v[6:0]}, 16'h0060);
        rdc(3'h5, 8'h60, "lsr no errors");
        i_ulc_serial_peer.send(16'h0244, 10);
        rdc(3'h0, 8'h22, "rx after break");
        $display("t_brk done");
    endtask
    task automatic t_frm();
        // low stop bit runs straight into the next character's data
        i_ulc_serial_peer.send(16'h014A, 10);
        i_ulc_serial_peer.send(16'h013C, 9);
        repeat (8) @(posedge ref_clk);
        rdc(3'h5, 8'hE9, "lsr framing");
        rdc(3'h0, 8'hA5, "rx framed");
        rdc(3'h5, 8'hE1, "lsr after framing");
        rdc(3'h0, 8'h3C, "rx resync");
        rdc(3'h5, 8'h60, "lsr resync empty");
        $display("t_frm done");
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        chk("rd in reset", {8'h00, regRdData}, 16'h0000);
        chk("out in reset", {15'h0, serialOutPin}, 16'h0001);
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdc(3'h5, 8'h60, "lsr reset");
        t_misc();
        t_tx(8'h1F, 8'hA5, 12, 16'h0D4A);
        t_tx(8'h0B, 8'hA5, 11, 16'h074A);
        wr(3'h4, 8'hEF);
        fifoEnable <= 1'b1;
        t_tx(8'h3B, 8'hFF, 11, 16'h05FE);
        t_tx(8'h2B, 8'h00, 11, 16'h0600);
        t_tx(8'h06, 8'h55, 10, 16'h03AA);
        t_tx(8'h05, 8'h2A, 9, 16'h01D4);
        wr(3'h4, 8'h00);
        t_rx_par();
        t_ovr();
        t_brk();
        t_frm();
        end_sim();
    end
endmodule
